// file: rtl/spare_channel_direction_ctrl.sv
// spare channel direction control at the input module end of the data cable
`timescale 1ns/1ps
`default_nettype none

module spare_sync3 #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output var  logic o_level
);
  logic s1;
  logic s2;
  logic s3;
  logic level;
  logic next_level;

  // a change counts once the second and third stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1    <= RESET_VALUE;
      s2    <= RESET_VALUE;
      s3    <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      s1    <= i_async;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule

module spare_channel_direction_ctrl (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rstn,
  input  wire logic                      i_input_side_direction_ctl,
  input  wire logic                      i_cable_present,
  input  wire logic                      i_transceivers_fitted,
  input  wire spare_dir_pkg::spare_pair_t i_spare_in,
  input  wire logic                      i_test_generator_control,
  input  wire logic                      i_observe_time_second_tick,
  output var  spare_dir_pkg::spare_pair_t o_spare_out,
  output var  spare_dir_pkg::spare_pair_t o_spare_oe_n,
  output var  spare_dir_pkg::spare_pair_t o_spare_rx,
  output var  logic                      o_reversed
);

  logic                              ctl_level;
  logic                              present_level;
  logic                              fitted_level;
  logic                              rx_one_level;
  logic                              rx_two_level;
  spare_dir_pkg::dir_state_t         state;
  spare_dir_pkg::dir_state_t         next_state;
  logic [spare_dir_pkg::GUARD_W-1:0] guard;
  logic [spare_dir_pkg::GUARD_W-1:0] next_guard;
  logic                              want_reverse;
  logic                              cmd_reverse;
  logic                              both_fitted;
  logic                              link_up;
  spare_dir_pkg::spare_pair_t        next_spare_out;
  spare_dir_pkg::spare_pair_t        next_spare_oe_n;
  spare_dir_pkg::spare_pair_t        next_spare_rx;
  logic                              next_reversed;

  // control level idles high when the line floats
  spare_sync3 #(.RESET_VALUE(spare_dir_pkg::CTL_FORWARD)) u_ctl_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_input_side_direction_ctl),
    .o_level   (ctl_level)
  );

  // cable presence
  spare_sync3 #(.RESET_VALUE(spare_dir_pkg::STRAP_RESET)) u_present_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_cable_present),
    .o_level   (present_level)
  );

  // transceiver strap
  spare_sync3 #(.RESET_VALUE(spare_dir_pkg::STRAP_RESET)) u_fitted_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_transceivers_fitted),
    .o_level   (fitted_level)
  );

  // received spare one, fail-safe high
  spare_sync3 #(.RESET_VALUE(spare_dir_pkg::LINE_IDLE)) u_rx_one_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_spare_in.one),
    .o_level   (rx_one_level)
  );

  // received spare two, fail-safe high
  spare_sync3 #(.RESET_VALUE(spare_dir_pkg::LINE_IDLE)) u_rx_two_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_spare_in.two),
    .o_level   (rx_two_level)
  );

  // command low means reverse permitted
  assign cmd_reverse  = (ctl_level == spare_dir_pkg::CTL_REVERSE);
  assign both_fitted  = fitted_level;
  assign link_up      = present_level;
  // reverse only when commanded low, both ends fitted and cable attached
  assign want_reverse = cmd_reverse && both_fitted && link_up;

  // turnaround state machine
  always_comb begin
    next_state = state;
    next_guard = guard;
    case (state)
      spare_dir_pkg::ST_FORWARD: begin
        if (want_reverse) begin
          next_state = spare_dir_pkg::ST_TURN_ON;
          next_guard = spare_dir_pkg::GUARD_LAST;
        end
      end
      spare_dir_pkg::ST_TURN_ON: begin
        // far end releases its drivers during the guard
        if (!want_reverse) begin
          next_state = spare_dir_pkg::ST_FORWARD;
        end else if (guard == spare_dir_pkg::GUARD_ZERO) begin
          next_state = spare_dir_pkg::ST_REVERSED;
        end else begin
          next_guard = guard - spare_dir_pkg::GUARD_STEP;
        end
      end
      spare_dir_pkg::ST_REVERSED: begin
        if (!want_reverse) begin
          next_state = spare_dir_pkg::ST_TURN_OFF;
          next_guard = spare_dir_pkg::GUARD_LAST;
        end
      end
      spare_dir_pkg::ST_TURN_OFF: begin
        // drivers already off; receive after the guard
        if (guard == spare_dir_pkg::GUARD_ZERO) begin
          next_state = spare_dir_pkg::ST_FORWARD;
        end else begin
          next_guard = guard - spare_dir_pkg::GUARD_STEP;
        end
      end
      default: begin
        next_state = spare_dir_pkg::ST_FORWARD;
        next_guard = spare_dir_pkg::GUARD_ZERO;
      end
    endcase
  end

  // spare drive and receive selection
  always_comb begin
    next_reversed   = (next_state == spare_dir_pkg::ST_REVERSED);
    next_spare_oe_n = spare_dir_pkg::PAIR_RELEASED;
    next_spare_out  = spare_dir_pkg::PAIR_IDLE;
    next_spare_rx   = spare_dir_pkg::PAIR_IDLE;
    if (next_reversed) begin
      next_spare_oe_n    = spare_dir_pkg::PAIR_DRIVING;
      // this input-side end puts its substitute clock and tick on this path
      next_spare_out.one = i_test_generator_control;
      next_spare_out.two = i_observe_time_second_tick;
    end else if (next_state == spare_dir_pkg::ST_FORWARD && present_level) begin
      next_spare_rx.one = rx_one_level;
      next_spare_rx.two = rx_two_level;
    end
  end

  // state, guard and registered outputs
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state        <= spare_dir_pkg::ST_FORWARD;
      guard        <= spare_dir_pkg::GUARD_ZERO;
      o_spare_out  <= spare_dir_pkg::PAIR_IDLE;
      o_spare_oe_n <= spare_dir_pkg::PAIR_RELEASED;
      o_spare_rx   <= spare_dir_pkg::PAIR_IDLE;
      o_reversed   <= 1'b0;
    end else begin
      state        <= next_state;
      guard        <= next_guard;
      o_spare_out  <= next_spare_out;
      o_spare_oe_n <= next_spare_oe_n;
      o_spare_rx   <= next_spare_rx;
      o_reversed   <= next_reversed;
    end
  end

endmodule

`default_nettype wire

// file: rtl/spare_dir_pkg.sv
// package: constants and types for the spare channel direction control
package spare_dir_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 40;
  // guard time between releasing one end's drivers and enabling the other's
  localparam int unsigned TURN_GUARD_NS  = 120;
  localparam int unsigned TURN_GUARD_CYC =
    ((TURN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((TURN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned GUARD_W        = 4;
  localparam logic [GUARD_W-1:0] GUARD_LAST = GUARD_W'(TURN_GUARD_CYC - 1);
  localparam logic [GUARD_W-1:0] GUARD_ZERO = 4'h0;
  localparam logic [GUARD_W-1:0] GUARD_STEP = 4'h1;
  // absent cable and missing strap read as low until synchronised
  localparam logic STRAP_RESET   = 1'b0;

  // line levels
  localparam logic LINE_IDLE     = 1'b1;
  localparam logic CTL_FORWARD   = 1'b1;
  localparam logic CTL_REVERSE   = 1'b0;
  localparam logic OE_N_RELEASED = 1'b1;
  localparam logic OE_N_DRIVING  = 1'b0;

  typedef struct packed {
    logic one;
    logic two;
  } spare_pair_t;

  localparam spare_pair_t PAIR_IDLE     = '{one: 1'b1, two: 1'b1};
  localparam spare_pair_t PAIR_RELEASED = '{one: 1'b1, two: 1'b1};
  localparam spare_pair_t PAIR_DRIVING  = '{one: 1'b0, two: 1'b0};

  typedef enum logic [1:0] {
    ST_FORWARD,
    ST_TURN_ON,
    ST_REVERSED,
    ST_TURN_OFF
  } dir_state_t;

endpackage

// file: dv/spare_dir_chk.sv
// checker for the spare channel direction control ports
`timescale 1ns/1ps
`default_nettype none
module spare_dir_chk (
  input wire logic                       i_ref_clk,
  input wire logic                       i_rstn,
  input wire logic                       i_input_side_direction_ctl,
  input wire logic                       i_cable_present,
  input wire logic                       i_transceivers_fitted,
  input wire logic                       i_test_generator_control,
  input wire logic                       i_observe_time_second_tick,
  input wire spare_dir_pkg::spare_pair_t o_spare_out,
  input wire spare_dir_pkg::spare_pair_t o_spare_oe_n,
  input wire spare_dir_pkg::spare_pair_t o_spare_rx,
  input wire logic                       o_reversed
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  sequence cmd_held;
    (!i_input_side_direction_ctl && i_transceivers_fitted && i_cable_present)[*8];
  endsequence
  sequence rx_held;
    (o_spare_rx == 2'h3)[*3];
  endsequence
  a_rev_entry: assert property (cmd_held |=> o_reversed)
    else $error("reversal late");
  a_rev_cause: assert property ($rose(o_reversed) |->
    !$past(i_input_side_direction_ctl, 5) && $past(i_transceivers_fitted, 5)
    && $past(i_cable_present, 5)) else $error("reversal without command");
  a_fwd_hold: assert property (i_input_side_direction_ctl[*6] |-> o_spare_oe_n == 2'h3)
    else $error("driving while forward");
  a_unplug_rel: assert property ((!i_cable_present)[*6] |->
    o_spare_oe_n == 2'h3 && o_spare_rx == 2'h3) else $error("unplugged not released");
  a_unfit_fwd: assert property ((!i_transceivers_fitted)[*6] |-> !o_reversed)
    else $error("reversed without transceivers");
  a_idle_one: assert property (!o_reversed |-> o_spare_out == 2'h3 && o_spare_oe_n == 2'h3)
    else $error("idle output not one");
  a_rev_drive: assert property (o_reversed |-> o_spare_oe_n == 2'h0 && o_spare_out ==
    {$past(i_test_generator_control), $past(i_observe_time_second_tick)})
    else $error("reverse data wrong");
  a_turn_guard: assert property ($fell(o_reversed) |-> rx_held)
    else $error("receive during turnaround");
endmodule
bind spare_channel_direction_ctrl spare_dir_chk u_chk (.i_ref_clk, .i_rstn,
  .i_input_side_direction_ctl, .i_cable_present, .i_transceivers_fitted,
  .i_test_generator_control, .i_observe_time_second_tick, .o_spare_out, .o_spare_oe_n,
  .o_spare_rx, .o_reversed);
`default_nettype wire

// file: dv/far_end_model.sv
// far end model: acquisition side of the data cable
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
  input  wire logic       i_cmd_rev,
  input  wire logic       i_plugged,
  input  wire logic [1:0] i_data,
  input  wire logic [1:0] i_dut_oe_n,
  input  wire logic [1:0] i_dut_out,
  output var  logic       o_ctl,
  output var  logic [1:0] o_line,
  output var  logic [1:0] o_back
);
  always_comb begin
    o_ctl = i_plugged ? !i_cmd_rev : 1'h1;
    o_line = 2'h3;
    if (i_plugged && !i_cmd_rev) o_line = i_data;
    else if (i_plugged && i_dut_oe_n == 2'h0) o_line = i_dut_out;
    o_back = o_line;
  end
endmodule
`default_nettype wire

// file: dv/tb_spare_channel_direction_ctrl.sv
// self-checking bench for the spare channel direction control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_spare_channel_direction_ctrl;
  logic i_ref_clk = 1'h0, i_rstn = 1'h0, cmd_rev = 1'h0, plugged = 1'h1, fitted = 1'h1;
  logic tgc = 1'h0, tick = 1'h0, ctl, rev;
  logic [1:0] fdata = 2'h3, line, back, v;
  spare_dir_pkg::spare_pair_t out, oe_n, rx;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  spare_channel_direction_ctrl DUT (.i_ref_clk, .i_rstn, .i_input_side_direction_ctl(ctl),
    .i_cable_present(plugged), .i_transceivers_fitted(fitted), .i_spare_in(line),
    .i_test_generator_control(tgc), .i_observe_time_second_tick(tick), .o_spare_out(out),
    .o_spare_oe_n(oe_n), .o_spare_rx(rx), .o_reversed(rev));
  far_end_model u_far (.i_cmd_rev(cmd_rev), .i_plugged(plugged), .i_data(fdata),
    .i_dut_oe_n(oe_n), .i_dut_out(out), .o_ctl(ctl), .o_line(line), .o_back(back));
  initial forever #20 i_ref_clk = ~i_ref_clk;
  task automatic go(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic rev_on();
    @(posedge i_ref_clk);
    cmd_rev <= 1'h1;
    go(7); #1;
    `CHK(rev, 1'h0)
    go(1); #1;
    `CHK({oe_n, rev}, 3'h1)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(3311));
    go(8);
    i_rstn <= 1'h1;
    #1;
    `CHK({out, oe_n, rx, rev}, 7'h7e)
    for (int i = 0; i < 6; i++) begin
      @(posedge i_ref_clk);
      v = i ? 2'($urandom) : 2'h0;
      fdata <= v;
      go(6); #1;
      `CHK(rx, v)
    end
    $display("test forward done");
    rev_on();
    repeat (8) begin
      @(posedge i_ref_clk);
      v = 2'($urandom);
      {tgc, tick} <= v;
      go(1); #1;
      `CHK({back, rx}, {v, 2'h3})
    end
    @(posedge i_ref_clk);
    cmd_rev <= 1'h0;
    go(5); #1;
    `CHK(oe_n, 2'h3)
    go(6); #1;
    `CHK(rx, fdata)
    $display("test reverse done");
    rev_on();
    @(posedge i_ref_clk);
    plugged <= 1'h0;
    go(5); #1;
    `CHK({oe_n, rev}, 3'h6)
    go(4); #1;
    `CHK(rx, 2'h3)
    @(posedge i_ref_clk);
    plugged <= 1'h1;
    fitted <= 1'h0;
    go(12); #1;
    `CHK(rev, 1'h0)
    $display("test unplug done");
    report_and_stop();
  end
endmodule
`default_nettype wire
